// ---- common/fwa_arbiter_defines.svh ----
`ifndef FWA_ARBITER_DEFINES_SVH
`define FWA_ARBITER_DEFINES_SVH

// ============================================================
// Arbitration sizing
// ============================================================
// Number of requesters on the shared bus
`define FWA_REQ_COUNT 4
// Width of the packed request code
`define FWA_CODE_W 4
// Code value with every request line high (none pending)
`define FWA_CODE_NONE 4'hf
// Synchroniser depth for pin inputs
`define FWA_SYNC_STAGES 2

// ============================================================
// Reset values
// ============================================================
// Award lines all negated out of reset
`define FWA_AWARD_RST 4'h0
// Request pins idle high, so synchronisers reset high
`define FWA_REQ_N_RST 4'hf
// Busy pin idle high (negated)
`define FWA_BUSY_N_RST 1'h1

// ============================================================
// Award vector bit positions
// ============================================================
`define FWA_BIT_TOP 3
`define FWA_BIT_SECOND 2
`define FWA_BIT_THIRD 1
`define FWA_BIT_LOWEST 0

`endif

// ---- common/fwa_arbiter_pkg.sv ----
package fwa_arbiter_pkg;

    // ============================================================
    // Major arbiter states
    // ============================================================
    typedef enum logic [2:0] {
        FWA_IDLE,
        FWA_SERVE_TOP,
        FWA_SERVE_SECOND,
        FWA_SERVE_THIRD,
        FWA_SERVE_LOWEST
    } fwa_state_t;

    // ============================================================
    // Handshake phase inside a service state
    // ============================================================
    typedef enum logic [1:0] {
        FWA_PH_AWARD,
        FWA_PH_OWNED,
        FWA_PH_RELEASE
    } fwa_phase_t;

    // ============================================================
    // Active-low request group, one line per requester
    // ============================================================
    typedef struct packed {
        logic top_n;
        logic second_n;
        logic third_n;
        logic lowest_n;
    } fwa_req_t;

endpackage

// ---- hdl/fwa_code_decode.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "fwa_arbiter_defines.svh"

// ============================================================
// Request code to next-state jump table
// ============================================================
module fwa_code_decode
    import fwa_arbiter_pkg::*;
(
    input wire logic [`FWA_CODE_W-1:0] code_in,
    output fwa_state_t next_state_out
);

    // code to state
    // Bit 0 of the code is the top request line, bit 3 the lowest
    always_comb begin
        case (code_in)
            // All high: nothing pending, stay idle
            `FWA_CODE_NONE: begin
                next_state_out = FWA_IDLE;
            end
            // Only the lowest line active
            4'h7: begin
                next_state_out = FWA_SERVE_LOWEST;
            end
            // Third line active, top two inactive
            4'h3, 4'hb: begin
                next_state_out = FWA_SERVE_THIRD;
            end
            // Second line active, top inactive
            4'h1, 4'h5, 4'h9, 4'hd: begin
                next_state_out = FWA_SERVE_SECOND;
            end
            // Every even code has the top line active
            default: begin
                next_state_out = FWA_SERVE_TOP;
            end
        endcase
    end

endmodule

`default_nettype wire

// ---- hdl/fwa_arbiter.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "fwa_arbiter_defines.svh"

module fwa_arbiter
    import fwa_arbiter_pkg::*;
(
    // 200 MHz system clock
    input wire logic clk_in,
    // Asynchronous active-low reset
    input wire logic nrst_in,
    // four lines, one each
    // Active-low request pins, one per requester
    input wire fwa_req_t bus_request_n_in,
    // Shared wired busy line, observed only
    input wire logic bus_occupied_n_in,
    // Active-high award lines, bit 3 is top priority
    output logic [`FWA_REQ_COUNT-1:0] bus_award_out,
    // High while a requester owns or is being given the bus
    output logic arb_active_out,
    // Index of the requester being served (3 = top)
    output logic [1:0] arb_owner_out
);

    // ============================================================
    // Declarations
    // ============================================================
    // First and second synchroniser stages for requests
    fwa_req_t req_meta;
    fwa_req_t req_sync;
    // First and second synchroniser stages for busy
    logic busy_meta_n;
    logic busy_sync_n;
    // Major state and handshake phase
    fwa_state_t state;
    fwa_state_t next_state;
    fwa_phase_t phase;
    fwa_phase_t next_phase;
    // State chosen by the jump table
    fwa_state_t table_state;
    // Request code as the jump table expects it
    logic [`FWA_CODE_W-1:0] req_code;
    // Synchronised busy, active high
    logic bus_busy;
    // One-hot award worked out from the next state
    logic [`FWA_REQ_COUNT-1:0] next_award;
    // Owner index for the current service state
    logic [1:0] state_owner;

    // ============================================================
    // Pin synchronisers
    // ============================================================
    // Requests come from other processors' clocks; the second
    // stage alone feeds the decode logic
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            req_meta <= `FWA_REQ_N_RST;
            req_sync <= `FWA_REQ_N_RST;
        end else begin
            req_meta <= bus_request_n_in;
            req_sync <= req_meta;
        end
    end

    // observe busy only
    // Busy is wired-or on the board; this block has no drive on it
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            busy_meta_n <= `FWA_BUSY_N_RST;
            busy_sync_n <= `FWA_BUSY_N_RST;
        end else begin
            busy_meta_n <= bus_occupied_n_in;
            busy_sync_n <= busy_meta_n;
        end
    end

    assign bus_busy = ~busy_sync_n;

    // ============================================================
    // Request code and jump table
    // ============================================================
    // build request code
    // Lowest line lands in bit 3, top line in bit 0
    assign req_code = {req_sync.lowest_n, req_sync.third_n,
                       req_sync.second_n, req_sync.top_n};

    // parallel decode
    // All four lines go through one table lookup per clock, so the
    // decision never waits on a scan of the lines
    fwa_code_decode u_decode (
        .code_in(req_code),
        .next_state_out(table_state)
    );

    // ============================================================
    // Per-state owner
    // ============================================================
    // shared handshake
    // Service states differ only in this owner mapping and in their award bit
    always_comb begin
        state_owner = 2'h0;
        case (state)
            FWA_SERVE_TOP: begin
                state_owner = 2'h3;
            end
            FWA_SERVE_SECOND: begin
                state_owner = 2'h2;
            end
            FWA_SERVE_THIRD: begin
                state_owner = 2'h1;
            end
            FWA_SERVE_LOWEST: begin
                state_owner = 2'h0;
            end
            // Idle serves nobody
            default: begin
                state_owner = 2'h0;
            end
        endcase
    end

    // ============================================================
    // Next state and phase
    // ============================================================
    // level interlock
    // Every step but the release settle cycle waits on the observed busy level; no timers, so
    // a slow requester simply stretches the phase
    always_comb begin
        next_state = state;
        next_phase = phase;
        case (state)
            FWA_IDLE: begin
                // arbitrate when free
                // A busy bus blocks any choice, even with requests low
                if (!bus_busy) begin
                    next_state = table_state;
                    next_phase = FWA_PH_AWARD;
                end else begin
                    next_state = FWA_IDLE;
                    next_phase = FWA_PH_AWARD;
                end
            end
            default: begin
                case (phase)
                    // Award held until the owner raises busy
                    FWA_PH_AWARD: begin
                        if (bus_busy) begin
                            next_phase = FWA_PH_OWNED;
                        end
                    end
                    // award withdrawn
                    // Wait here for the owner to let go
                    FWA_PH_OWNED: begin
                        if (!bus_busy) begin
                            next_phase = FWA_PH_RELEASE;
                        end
                    end
                    // rearbitrate after release
                    // One settle cycle, then back to idle decode
                    FWA_PH_RELEASE: begin
                        next_state = FWA_IDLE;
                        next_phase = FWA_PH_AWARD;
                    end
                    default: begin
                        next_state = FWA_IDLE;
                        next_phase = FWA_PH_AWARD;
                    end
                endcase
            end
        endcase
    end

    // ============================================================
    // State registers
    // ============================================================
    // reset to idle
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state <= FWA_IDLE;
            phase <= FWA_PH_AWARD;
        end else begin
            state <= next_state;
            phase <= next_phase;
        end
    end

    // ============================================================
    // Award output
    // ============================================================
    // Award is driven from the next state so the line rises on the
    // same edge that enters the service state
    always_comb begin
        next_award = `FWA_AWARD_RST;
        case (next_state)
            FWA_SERVE_TOP: begin
                next_award[`FWA_BIT_TOP] = (next_phase == FWA_PH_AWARD);
            end
            FWA_SERVE_SECOND: begin
                next_award[`FWA_BIT_SECOND] = (next_phase == FWA_PH_AWARD);
            end
            FWA_SERVE_THIRD: begin
                next_award[`FWA_BIT_THIRD] = (next_phase == FWA_PH_AWARD);
            end
            FWA_SERVE_LOWEST: begin
                next_award[`FWA_BIT_LOWEST] = (next_phase == FWA_PH_AWARD);
            end
            default: begin
                next_award = `FWA_AWARD_RST;
            end
        endcase
    end

    // single award
    // At most one bit set, only in the award phase
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            bus_award_out <= `FWA_AWARD_RST;
        end else begin
            bus_award_out <= next_award;
        end
    end

    // ============================================================
    // Status outputs
    // ============================================================
    // Registered view of who is being served
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            arb_active_out <= 1'b0;
            arb_owner_out <= 2'h0;
        end else begin
            arb_active_out <= (state != FWA_IDLE);
            arb_owner_out <= state_owner;
        end
    end

endmodule

`default_nettype wire

// ---- testbench/fwa_arbiter_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module fwa_arbiter_chk
    import fwa_arbiter_pkg::*;
(
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire fwa_req_t bus_request_n_in,
    input wire logic bus_occupied_n_in,
    input wire logic [3:0] bus_award_out,
    input wire logic arb_active_out,
    input wire logic [1:0] arb_owner_out
);
    // ============================================================
    // Helpers
    // ============================================================
    // Winner of an active-low request group, top first
    function automatic logic [3:0] pick(input logic [3:0] r);
        pick = !r[3] ? 4'h8 : !r[2] ? 4'h4 : !r[1] ? 4'h2 : !r[0] ? 4'h1 : 4'h0;
    endfunction
    default clocking @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    // ============================================================
    // Properties
    // ============================================================
    property p_one_award; $onehot0(bus_award_out); endproperty
    a_one_award: assert property (p_one_award) else $error("two awards at once");
    // Decision uses pins three samples back: two synchroniser stages
    // plus the award register between decision and this sample
    property p_priority;
        $rose(|bus_award_out) |-> bus_award_out == pick($past(bus_request_n_in, 3));
    endproperty
    a_priority: assert property (p_priority) else $error("award not top pending");
    property p_free_bus; $rose(|bus_award_out) |-> $past(bus_occupied_n_in, 3); endproperty
    a_free_bus: assert property (p_free_bus) else $error("award while bus busy");
    property p_withdraw;
        $fell(bus_occupied_n_in) && bus_award_out != 4'h0 |-> ##[1:3] bus_award_out == 4'h0;
    endproperty
    a_withdraw: assert property (p_withdraw) else $error("award kept after busy");
    property p_stands; bus_occupied_n_in [*3] ##0 bus_award_out != 4'h0 |=> $stable(bus_award_out);
    endproperty
    a_stands: assert property (p_stands) else $error("award dropped early");
    property p_idle;
        (bus_request_n_in == 4'hf) [*3] ##0 bus_award_out == 4'h0 |=> bus_award_out == 4'h0;
    endproperty
    a_idle: assert property (p_idle) else $error("award with no request");
    property p_owner;
        $rose(|bus_award_out) |=> arb_active_out && (4'h1 << arb_owner_out) == bus_award_out;
    endproperty
    a_owner: assert property (p_owner) else $error("status not matching award");
    // A fresh request on a free idle bus is awarded within three cycles
    property p_latency;
        bus_occupied_n_in [*3] ##0 ($past(bus_request_n_in) == 4'hf && bus_request_n_in != 4'hf
            && !arb_active_out && bus_award_out == 4'h0) |-> ##[1:3] bus_award_out != 4'h0;
    endproperty
    a_latency: assert property (p_latency) else $error("decision too slow");
    property p_reset; $rose(nrst_in) |-> bus_award_out == 4'h0 && !arb_active_out; endproperty
    a_reset: assert property (p_reset) else $error("outputs live after reset");
    c_top: cover property ($rose(bus_award_out[3]));
    c_low: cover property ($rose(bus_award_out[0]));
    c_drop: cover property ($fell(|bus_award_out));
endmodule
bind fwa_arbiter fwa_arbiter_chk u_chk (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .bus_request_n_in(bus_request_n_in),
    .bus_occupied_n_in(bus_occupied_n_in),
    .bus_award_out(bus_award_out),
    .arb_active_out(arb_active_out),
    .arb_owner_out(arb_owner_out)
);
`default_nettype wire

// ---- testbench/fwa_proc_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module fwa_proc_model
    import fwa_arbiter_pkg::*;
(
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic [3:0] award_in,
    input wire logic [7:0] hold_in,
    output fwa_req_t req_n_out,
    output logic busy_n_out
);
    logic [3:0] pending = 4'h0; // Wanted, bit 3 top
    logic [3:0] pull = 4'h0; // Who pulls busy
    int cnt = 0; // Ownership cycles left
    int order_q[$]; // Service order seen
    assign req_n_out = ~pending;
    assign busy_n_out = ~|pull;
    task automatic request(input logic [3:0] m);
        pending = pending | m;
    endtask
    // Acts 1 ns after the edge, the same delay the bench drives with;
    // reset is looked at again after the delay, so a reset applied in
    // that same time step is never missed
    always @(posedge clk_in or negedge nrst_in) begin
        if (nrst_in) begin
            #1;
        end
        if (!nrst_in) begin
            pending = 4'h0;
            pull = 4'h0;
        end else if (pull == 4'h0) begin
            for (int i = 0; i < 4; i++) begin
                if (award_in[i] && pending[i] && pull == 4'h0) begin
                    pull[i] = 1'b1;
                    cnt = hold_in;
                    order_q.push_back(i);
                end
            end
        end else if (cnt > 0) begin
            cnt--;
        end else if ((pending & pull) != 4'h0) begin
            pending = pending & ~pull;
        end else begin
            pull = 4'h0;
        end
    end
endmodule
`default_nettype wire

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import fwa_arbiter_pkg::*;
;
    logic clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic [7:0] hold = 8'h04; // Prompt ownership length
    fwa_req_t req_n;
    logic busy_n;
    logic [3:0] award;
    logic active;
    logic [1:0] owner;
    int err_count = 0;
    int comparisons = 0;
    initial forever #2.5 clk_in = ~clk_in;
    fwa_arbiter uut (.clk_in(clk_in), .nrst_in(nrst_in), .bus_request_n_in(req_n),
        .bus_occupied_n_in(busy_n), .bus_award_out(award), .arb_active_out(active),
        .arb_owner_out(owner));
    fwa_proc_model model (.clk_in(clk_in), .nrst_in(nrst_in), .award_in(award),
        .hold_in(hold), .req_n_out(req_n), .busy_n_out(busy_n));
    // ============================================================
    // Shared tasks
    // ============================================================
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Bounded wait for n services and a quiet bus
    task automatic wait_idle(input int n);
        int k;
        for (k = 0; k < 4000; k++) begin
            @(posedge clk_in);
            if (model.order_q.size() == n && busy_n === 1'b1 && award === 4'h0
                && model.pending === 4'h0) break;
        end
        if (k == 4000) begin
            err_count++;
            $display("ERROR %0t: service timeout", $time);
            final_report();
        end
        #1;
    endtask
    task automatic wait_award(input int i);
        int k;
        for (k = 0; k < 100 && award[i] !== 1'b1; k++) @(posedge clk_in);
        check(k < 100, 1);
        // A missing award ends the run rather than stalling later steps
        if (k == 100) begin
            final_report();
        end
        #1;
    endtask
    // ============================================================
    // Scenarios
    // ============================================================
    task automatic s_idle();
        repeat (20) begin
            @(posedge clk_in);
            #1;
            check({active, owner, award}, 32'h0);
        end
    endtask
    // Every request code, served strictly top first
    task automatic s_codes();
        int n;
        for (int c = 1; c < 16; c++) begin
            model.order_q.delete();
            model.request(c[3:0]);
            wait_idle($countones(c[3:0]));
            n = 0;
            for (int i = 3; i >= 0; i--) begin
                if (c[i]) begin
                    check(model.order_q[n], i);
                    n++;
                end
            end
        end
    endtask
    // Higher requests arrive while the lowest owns a slow bus
    task automatic s_preempt();
        hold = 8'h14;
        model.order_q.delete();
        model.request(4'h1);
        wait_award(0);
        model.request(4'ha);
        wait_idle(3);
        check(model.order_q[0], 0);
        check(model.order_q[1], 3);
        check(model.order_q[2], 1);
        hold = 8'h04;
    endtask
    // Reset in mid service drops the award
    task automatic s_reset();
        model.order_q.delete();
        model.request(4'h8);
        wait_award(3);
        nrst_in = 1'b0;
        repeat (2) @(posedge clk_in);
        #1;
        check({active, owner, award}, 32'h0);
        nrst_in = 1'b1;
        s_idle();
    endtask
    initial begin
        repeat (12) @(posedge clk_in);
        #1;
        nrst_in = 1'b1;
        s_idle();
        s_codes();
        s_preempt();
        s_reset();
        final_report();
    end
endmodule
`default_nettype wire
